// [design/bridge_pm_pkg.sv]
package bridge_pm_pkg;

	// Power states, Gray coded along off -> d0u -> d0a -> d1 -> d2 -> d3
	typedef enum logic [2:0] {
		ST_OFF      = 3'h0,
		ST_D0_UNINIT = 3'h1,
		ST_D0_ACTIVE = 3'h3,
		ST_D1       = 3'h2,
		ST_D2       = 3'h6,
		ST_D3       = 3'h7
	} power_state_type;

	typedef enum logic [1:0] {
		REQ_D0 = 2'h0,
		REQ_D1 = 2'h1,
		REQ_D2 = 2'h2,
		REQ_D3 = 2'h3
	} state_req_type;

	// Card-side pins, all asynchronous to clk
	typedef struct packed {
		logic clock_run_req;
		logic func_irq;
		logic status_change;
		logic card_present;
		logic card_wake;
	} card_pins_type;

	// Upstream cycle decode, same clock domain
	typedef struct packed {
		logic valid;
		logic is_config;
		logic is_type0;
		logic self_select;
	} pci_cycle_type;

	localparam int unsigned    SYNC_WIDTH  = 7;
	localparam int unsigned    SYNC_STAGES = 2;
	localparam logic [1:0]     VCC_OFF     = 2'h0;
	localparam power_state_type STATE_RESET = ST_OFF;
	localparam logic [1:0]     VCC_RESET   = VCC_OFF;

endpackage

// [design/pin_sync.sv]
module pin_sync
	import bridge_pm_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Pins
	input  wire logic [SYNC_WIDTH-1:0] pin_async,
	output logic      [SYNC_WIDTH-1:0] pin_sync
);

	logic [SYNC_WIDTH-1:0] stage1_q;
	logic [SYNC_WIDTH-1:0] stage2_q;

	genvar i;
	generate
		for (i = 0; i < SYNC_WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					stage1_q[i] <= 1'b0;
					stage2_q[i] <= 1'b0;
				end
				else
				begin
					stage1_q[i] <= pin_async[i];
					stage2_q[i] <= stage1_q[i];
				end
			end
		end
	endgenerate

	assign pin_sync = stage2_q;

endmodule // pin_sync

// [design/bridge_low_power_states.sv]
module bridge_low_power_states
	import bridge_pm_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Asynchronous pins
	input  wire card_pins_type card_pins,
	input  wire logic          seg_reset_pin,
	input  wire logic          power_good_pin,
	// Software control, same clock
	input  wire logic          state_req_valid,
	input  wire state_req_type state_req,
	input  wire logic          wake_event_enable,
	input  wire logic          clock_run_supported,
	input  wire logic          clock_run_stop,
	input  wire logic          vcc_write,
	input  wire logic [1:0]    vcc_req,
	input  wire logic          removal_ack,
	input  wire pci_cycle_type pci_cycle,
	// Status and control outputs
	output power_state_type    state_q,
	output logic               card_clk_en_q,
	output logic               card_bus_idle_q,
	output logic               card_irq_q,
	output logic               socket_status_change_irq_q,
	output logic               pci_irq_q,
	output logic               wake_o_q,
	output logic               wake_oe_n_q,
	output logic [1:0]         slot_vcc_q,
	output logic               card_removed_q,
	output logic               cycle_claim_q,
	output logic               func_access_q,
	output logic               config_access_q
);

	logic [SYNC_WIDTH-1:0] pins_s;
	card_pins_type         card_s;
	logic                  seg_reset_s;
	logic                  power_good_s;

	pin_sync u_sync (
		.clk       (clk),
		.rst       (rst),
		.pin_async ({card_pins, seg_reset_pin, power_good_pin}),
		.pin_sync  (pins_s)
	);

	assign card_s       = pins_s[SYNC_WIDTH-1:2];
	assign seg_reset_s  = pins_s[1];
	assign power_good_s = pins_s[0];

	// State machine
	power_state_type state_d;

	always_comb
	begin
		state_d = state_q;
		if (!power_good_s)
			state_d = ST_OFF;
		else if (seg_reset_s)
			state_d = ST_D0_UNINIT;
		else if (state_q == ST_OFF)
			state_d = ST_D0_UNINIT;
		else if (state_req_valid)
		begin
			case (state_q)
				ST_D0_UNINIT:
					if (state_req == REQ_D0)
						state_d = ST_D0_ACTIVE;
					else if (state_req == REQ_D3)
						state_d = ST_D3;
				ST_D0_ACTIVE:
					if (state_req == REQ_D1)
						state_d = ST_D1;
					else if (state_req == REQ_D2)
						state_d = ST_D2;
					else if (state_req == REQ_D3)
						state_d = ST_D3;
				ST_D1:
					if (state_req == REQ_D0)
						state_d = ST_D0_ACTIVE;
					else if (state_req == REQ_D2)
						state_d = ST_D2;
					else if (state_req == REQ_D3)
						state_d = ST_D3;
				ST_D2:
					if (state_req == REQ_D0)
						state_d = ST_D0_ACTIVE;
					else if (state_req == REQ_D3)
						state_d = ST_D3;
				ST_D3:
					if (state_req == REQ_D0)
						state_d = ST_D0_UNINIT;
				default:
					state_d = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= STATE_RESET;
		else
			state_q <= state_d;
	end

	// Output group, decoded from the current state
	logic       low_power;
	logic       active;
	logic       present_prev_q;
	logic       removal_evt;
	logic       card_clk_en_d;
	logic       card_bus_idle_d;
	logic       card_irq_d;
	logic       status_irq_d;
	logic       pci_irq_d;
	logic       wake_drive_d;
	logic [1:0] slot_vcc_d;
	logic       card_removed_d;
	logic       cycle_claim_d;
	logic       func_access_d;
	logic       config_access_d;

	assign low_power   = (state_q == ST_D1) || (state_q == ST_D2);
	assign active      = (state_q == ST_D0_ACTIVE);
	// Removal seen in every powered state, low power included
	assign removal_evt = present_prev_q && !card_s.card_present;

	always_comb
	begin
		card_clk_en_d = 1'b0;
		case (state_q)
			ST_D0_ACTIVE, ST_D1:
				card_clk_en_d = clock_run_supported ? !clock_run_stop : 1'b1;
			ST_D2:
				card_clk_en_d = clock_run_supported && card_s.clock_run_req;
			default:
				card_clk_en_d = 1'b0;
		endcase
		card_bus_idle_d = !active;
		// Interrupts only pass in D0 active
		card_irq_d      = active && card_s.func_irq;
		status_irq_d    = active && card_s.status_change;
		pci_irq_d       = active && (card_s.func_irq || card_s.status_change);
		wake_drive_d    = wake_event_enable && (active || low_power)
			&& (card_s.card_wake || removal_evt);
		// Slot supply frozen outside D0 active except for removal
		slot_vcc_d = slot_vcc_q;
		if (removal_evt)
			slot_vcc_d = VCC_OFF;
		else if (active && vcc_write)
			slot_vcc_d = vcc_req;
		// Set wins over acknowledge
		card_removed_d  = removal_evt || (card_removed_q && !removal_ack);
		cycle_claim_d   = pci_cycle.valid && (active || (state_q != ST_OFF
			&& pci_cycle.is_config && pci_cycle.is_type0 && pci_cycle.self_select));
		func_access_d   = active;
		config_access_d = (state_q != ST_OFF);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			present_prev_q             <= 1'b0;
			card_clk_en_q              <= 1'b0;
			card_bus_idle_q            <= 1'b1;
			card_irq_q                 <= 1'b0;
			socket_status_change_irq_q <= 1'b0;
			pci_irq_q                  <= 1'b0;
			wake_o_q                   <= 1'b0;
			wake_oe_n_q                <= 1'b1;
			slot_vcc_q                 <= VCC_RESET;
			card_removed_q             <= 1'b0;
			cycle_claim_q              <= 1'b0;
			func_access_q              <= 1'b0;
			config_access_q            <= 1'b0;
		end
		else
		begin
			present_prev_q             <= card_s.card_present;
			card_clk_en_q              <= card_clk_en_d;
			card_bus_idle_q            <= card_bus_idle_d;
			card_irq_q                 <= card_irq_d;
			socket_status_change_irq_q <= status_irq_d;
			pci_irq_q                  <= pci_irq_d;
			wake_o_q                   <= 1'b0;
			wake_oe_n_q                <= !wake_drive_d;
			slot_vcc_q                 <= slot_vcc_d;
			card_removed_q             <= card_removed_d;
			cycle_claim_q              <= cycle_claim_d;
			func_access_q              <= func_access_d;
			config_access_q            <= config_access_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_in_d1;
		state_q == ST_D1 && power_good_s && !seg_reset_s;
	endsequence

	a_d1_clock_on: assert property ((s_in_d1 and !clock_run_supported) |=> card_clk_en_q)
		else $error("card clock stopped in D1 without clock run");
	a_d2_clock_off: assert property ((state_q == ST_D2 && !clock_run_supported && power_good_s
		&& !seg_reset_s) |=> !card_clk_en_q)
		else $error("card clock running in D2 without clock run");
	a_low_no_irq: assert property ($past(low_power) |-> !card_irq_q && !socket_status_change_irq_q)
		else $error("card interrupt delivered in low power");
	a_wake_gated: assert property (!$past(wake_event_enable) |-> wake_oe_n_q)
		else $error("wake driven with enable clear");
	a_removal_flag: assert property ($past(removal_evt) |-> card_removed_q && slot_vcc_q == VCC_OFF)
		else $error("card removal missed");
	a_vcc_hold: assert property ((low_power && !removal_evt) |=> $stable(slot_vcc_q))
		else $error("slot supply changed in low power");
	a_no_pci_irq: assert property ($past(low_power) |-> !pci_irq_q)
		else $error("upstream interrupt in low power");
	a_claim_type0: assert property ((low_power && pci_cycle.valid && !pci_cycle.is_type0)
		|=> !cycle_claim_q)
		else $error("non type 0 cycle claimed in low power");
	a_d2_exits: assert property ((state_q == ST_D2) |=> state_q inside {ST_D2, ST_D0_ACTIVE,
		ST_D3, ST_D0_UNINIT, ST_OFF})
		else $error("illegal exit from D2");
	a_seg_reset: assert property ((power_good_s && seg_reset_s) |=> state_q == ST_D0_UNINIT)
		else $error("segment reset ignored");

endmodule // bridge_low_power_states

// [testbench/card_model.sv]
module card_model
	import bridge_pm_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// Bridge side
	input  wire power_state_type bridge_state,
	// Scenario pin pattern
	input  wire logic [4:0]      ctl,
	// Card pins
	output card_pins_type        pins
);
	timeunit 1ns;
	timeprecision 1ns;
	power_state_type card_state_q;
	// Card copies the bridge state one cycle later, only while the bridge is in D1 or D2
	always_ff @(posedge clk or posedge rst)
		if (rst)
			card_state_q <= ST_D0_ACTIVE;
		else if (bridge_state == ST_D1 || bridge_state == ST_D2)
			card_state_q <= bridge_state;
	assign pins = card_pins_type'(ctl);
endmodule // card_model

// [testbench/tb.sv]
module tb;
	import bridge_pm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic            clk, rst, srv, wen, crs, crst, vw, rack, seg, pg;
	logic [1:0]      vr, vcc;
	logic [4:0]      ctl;
	state_req_type   sr;
	pci_cycle_type   cyc;
	card_pins_type   pins;
	power_state_type st;
	logic            cke, idle, cirq, sirq, pirq, wo, woe, rem, clm, fa, ca;
	int              fails = 0, num_checks = 0;
	card_model card (.clk(clk), .rst(rst), .bridge_state(st), .ctl(ctl), .pins(pins));
	bridge_low_power_states DUT (.clk(clk), .rst(rst), .card_pins(pins), .seg_reset_pin(seg),
		.power_good_pin(pg), .state_req_valid(srv), .state_req(sr), .wake_event_enable(wen),
		.clock_run_supported(crs), .clock_run_stop(crst), .vcc_write(vw), .vcc_req(vr),
		.removal_ack(rack), .pci_cycle(cyc), .state_q(st), .card_clk_en_q(cke),
		.card_bus_idle_q(idle), .card_irq_q(cirq), .socket_status_change_irq_q(sirq),
		.pci_irq_q(pirq), .wake_o_q(wo), .wake_oe_n_q(woe), .slot_vcc_q(vcc),
		.card_removed_q(rem), .cycle_claim_q(clm), .func_access_q(fa), .config_access_q(ca));
	// Upstream clock kept running throughout, allowed in both low states
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic go(input state_req_type r);
		@(posedge clk);
		srv <= 1'b1;
		sr  <= r;
		@(posedge clk);
		srv <= 1'b0;
		tick(2);
	endtask
	// Extra edges cover the two-stage pin synchroniser
	task automatic pins_to(input logic [4:0] v);
		@(posedge clk);
		ctl <= v;
		tick(5);
	endtask
	task automatic vcc_pulse(input logic [1:0] v);
		@(posedge clk);
		vw <= 1'b1;
		vr <= v;
		@(posedge clk);
		vw <= 1'b0;
		tick(2);
	endtask
	task automatic t_power_up;
		tick(6);
		check(st, ST_D0_UNINIT);
		go(REQ_D1);
		check(st, ST_D0_UNINIT);
		go(REQ_D0);
		vcc_pulse(2'h2);
		pins_to(5'h0E);
		check({cirq, sirq, pirq, vcc}, 8'h1E);
		$display("power up test done");
	endtask
	task automatic t_d1;
		go(REQ_D1);
		check({st, cirq, sirq, pirq}, 8'h10);
		check(card.card_state_q, ST_D1);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			crs  <= i[1];
			crst <= i[0];
			tick(3);
			check(cke, i != 3);
		end
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk);
			cyc <= pci_cycle_type'(i[3:0]);
			@(posedge clk);
			cyc <= '0;
			#1;
			check(clm, i == 15);
		end
		check({fa, ca}, 8'h01);
		vcc_pulse(2'h1);
		check(vcc, 8'h02);
		pins_to(5'h03);
		check(woe, 8'h01);
		@(posedge clk);
		wen <= 1'b1;
		tick(3);
		check(woe, 8'h00);
		check(wo, 8'h00);
		@(posedge clk);
		wen <= 1'b0;
		pins_to(5'h02);
		$display("d1 test done");
	endtask
	task automatic t_d2;
		go(REQ_D2);
		go(REQ_D1);
		check({st, idle}, 8'h0D);
		check(card.card_state_q, ST_D2);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			crs <= i[1];
			pins_to({i[0], 4'h2});
			check(cke, i == 3);
		end
		pins_to(5'h00);
		check({rem, vcc}, 8'h04);
		@(posedge clk);
		rack <= 1'b1;
		@(posedge clk);
		rack <= 1'b0;
		tick(2);
		check(rem, 8'h00);
		@(posedge clk);
		seg <= 1'b1;
		tick(5);
		check(st, ST_D0_UNINIT);
		@(posedge clk);
		seg <= 1'b0;
		pg  <= 1'b0;
		tick(5);
		check(st, ST_OFF);
		$display("d2 test done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Whole run is some 160 cycles, about 6.3 us
	initial
	begin
		#40us;
		fails++;
		end_sim();
	end
	initial
	begin
		rst = 1'b1;
		{srv, wen, crs, crst, vw, rack, seg} = '0;
		pg  = 1'b1;
		sr  = REQ_D0;
		vr  = 2'h0;
		ctl = 5'h02;
		cyc = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_power_up();
		t_d1();
		t_d2();
		end_sim();
	end
endmodule // tb
